// [hdl/aoc_map.vh]
`ifndef AOC_MAP_VH
`define AOC_MAP_VH
// clock
`define AOC_CLK_NS 5
// register byte offsets
`define AOC_CTRL_OFS 4'h0
`define AOC_STATUS_OFS 4'h4
`define AOC_CTRL_RST 10'h000
// control field positions
`define AOC_C_HALF 0
`define AOC_C_FMT 1
`define AOC_C_FAST 2
`define AOC_C_RATE 3
`define AOC_C_IFACE 4
`define AOC_C_SRC 5
`define AOC_C_RDT 6
`define AOC_C_DIV_LO 8
`define AOC_C_DIV_HI 9
// status field positions
`define AOC_S_MODE_LO 0
`define AOC_S_MODE_HI 2
`define AOC_S_LATE 3
`define AOC_S_BUSY 4
`define AOC_S_CNT_LO 8
`define AOC_S_CNT_HI 11
// axi responses
`define AOC_RESP_OKAY 2'h0
`define AOC_RESP_SLVERR 2'h2
// result width
`define AOC_RES_W 16
// least serial clock periods in ns per divide code
`define AOC_SCLK_NS_0 8
`define AOC_SCLK_NS_1 16
`define AOC_SCLK_NS_2 32
`define AOC_SCLK_NS_3 64
// least times round up to whole cycles
`define AOC_SCLK_CYC_0 ((`AOC_SCLK_NS_0 + `AOC_CLK_NS - 1) / `AOC_CLK_NS)
`define AOC_SCLK_CYC_1 ((`AOC_SCLK_NS_1 + `AOC_CLK_NS - 1) / `AOC_CLK_NS)
`define AOC_SCLK_CYC_2 ((`AOC_SCLK_NS_2 + `AOC_CLK_NS - 1) / `AOC_CLK_NS)
`define AOC_SCLK_CYC_3 ((`AOC_SCLK_NS_3 + `AOC_CLK_NS - 1) / `AOC_CLK_NS)
// longest gap between conversions in fast modes
`define AOC_MAX_GAP_MS 1
`define AOC_MAX_GAP_CYC (`AOC_MAX_GAP_MS * 1000000 / `AOC_CLK_NS)
`endif

// [hdl/aoc_top.v]
`timescale 1ns/1ps
`include "aoc_map.vh"

// result fifo, valid and ready on both sides
module aoc_fifo #(
  parameter W = 16,
  parameter D = 8,
  parameter AW = 3
) (
  input wire aclk,
  input wire aresetn,
  input wire [W-1:0] in_data,
  input wire in_valid,
  output wire in_ready,
  output wire [W-1:0] out_data,
  output wire out_valid,
  input wire out_ready,
  output wire [AW:0] level
);
  reg [W-1:0] mem [0:D-1];
  reg [AW-1:0] wp_reg;
  reg [AW-1:0] rp_reg;
  reg [AW:0] cnt_reg;
  wire push;
  wire pop;

  assign in_ready = (cnt_reg != D[AW:0]);
  assign out_valid = (cnt_reg != {(AW+1){1'b0}});
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rp_reg];
  assign level = cnt_reg;

  // storage write
  always @(posedge aclk) begin
    if (push) begin
      mem[wp_reg] <= in_data;
    end
  end

  // pointers and fill count
  always @(posedge aclk) begin
    if (!aresetn) begin
      wp_reg <= {AW{1'b0}};
      rp_reg <= {AW{1'b0}};
      cnt_reg <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wp_reg <= (wp_reg == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp_reg + 1'b1;
      end
      if (pop) begin
        rp_reg <= (rp_reg == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp_reg + 1'b1;
      end
      if (push && !pop) begin
        cnt_reg <= cnt_reg + 1'b1;
      end else if (pop && !push) begin
        cnt_reg <= cnt_reg - 1'b1;
      end
    end
  end
endmodule // aoc_fifo

module aoc_top #(
  parameter FIFO_DEPTH = 8,
  parameter FIFO_AW = 3,
  parameter MAX_GAP_CYC = `AOC_MAX_GAP_CYC
) (
  input wire aclk,
  input wire aresetn,
  input wire [3:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [3:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [15:0] conv_data,
  input wire conv_valid,
  output wire conv_ready,
  input wire par_read,
  output wire [15:0] d_out,
  output wire [15:0] d_oe,
  input wire cs_n,
  input wire sclk_in,
  output wire sclk_out,
  output wire sclk_oe,
  output wire serial_result_out,
  output wire serial_result_oe
);
  localparam ST_IDLE = 2'b01;
  localparam ST_SHIFT = 2'b10;
  localparam [6:0] PER_0 = `AOC_SCLK_CYC_0, PER_1 = `AOC_SCLK_CYC_1;
  localparam [6:0] PER_2 = `AOC_SCLK_CYC_2, PER_3 = `AOC_SCLK_CYC_3;
  reg [9:0] ctrl_reg;
  reg [3:0] awaddr_reg;
  reg aw_got_reg;
  reg w_got_reg;
  reg [31:0] wdata_reg;
  reg [3:0] wstrb_reg;
  reg bvalid_reg;
  reg [1:0] bresp_reg;
  reg rvalid_reg;
  reg [31:0] rdata_reg;
  reg [1:0] rresp_reg;
  reg late_reg;
  reg [31:0] gap_reg;
  reg [15:0] par_word_reg;
  reg [15:0] shift_reg;
  reg [4:0] bits_reg;
  reg [1:0] state_reg;
  reg [6:0] pcnt_reg;
  reg sclk_reg;
  reg sclk_in_prev_reg;
  reg sdo_reg;
  reg [6:0] period_next;
  reg pop_next;
  wire [15:0] head;
  wire head_valid;
  wire [FIFO_AW:0] level;
  wire [15:0] fmt_word;
  wire [2:0] mode_onehot;
  wire serial_mode;
  wire master_mode;
  wire [1:0] div_eff;
  wire wr_do;
  wire [31:0] status_word;
  wire shift_tick;
  wire conv_taken;
  aoc_fifo #(
    .W(`AOC_RES_W),
    .D(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) aoc_fifo_inst (
    .aclk(aclk),
    .aresetn(aresetn),
    .in_data(conv_data),
    .in_valid(conv_valid),
    .in_ready(conv_ready),
    .out_data(head),
    .out_valid(head_valid),
    .out_ready(pop_next),
    .level(level)
  );
  // mode decode, bit 0 fast wideband, bit 1 fast, bit 2 accurate
  assign mode_onehot[0] = ctrl_reg[`AOC_C_FAST] && ctrl_reg[`AOC_C_RATE];
  assign mode_onehot[1] = ctrl_reg[`AOC_C_FAST] && !ctrl_reg[`AOC_C_RATE];
  assign mode_onehot[2] = !ctrl_reg[`AOC_C_FAST] && !ctrl_reg[`AOC_C_RATE];
  assign serial_mode = ctrl_reg[`AOC_C_IFACE];
  assign master_mode = serial_mode && !ctrl_reg[`AOC_C_SRC];
  // divide applies only in master read after convert
  assign div_eff = ctrl_reg[`AOC_C_RDT] ? 2'h0 : ctrl_reg[`AOC_C_DIV_HI:`AOC_C_DIV_LO];
  // output code format
  assign fmt_word = {ctrl_reg[`AOC_C_FMT] ? head[15] : ~head[15], head[14:0]};
  assign conv_taken = conv_valid && conv_ready;
  // serial clock period per divide code
  always @* begin
    case (div_eff)
      2'h0: period_next = PER_0;
      2'h1: period_next = PER_1;
      2'h2: period_next = PER_2;
      default: period_next = PER_3;
    endcase
  end
  // shift instant: end of internal period or external rising edge
  assign shift_tick = master_mode ? (pcnt_reg == period_next - 7'h01) : (sclk_in && !sclk_in_prev_reg);
  // fifo pop: parallel read or start of a serial word
  always @* begin
    pop_next = 1'b0;
    if (!serial_mode) begin
      pop_next = par_read && head_valid;
    end else if (state_reg == ST_IDLE) begin
      pop_next = head_valid && !cs_n;
    end
  end
  // axi write address and data, taken in either order
  assign s_axi_awready = !aw_got_reg && !bvalid_reg;
  assign s_axi_wready = !w_got_reg && !bvalid_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign wr_do = aw_got_reg && w_got_reg && !bvalid_reg;
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      awaddr_reg <= 4'h0;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= `AOC_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (wr_do) begin
        aw_got_reg <= 1'b0;
        w_got_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= (awaddr_reg[3:2] == `AOC_CTRL_OFS >> 2 || awaddr_reg[3:2] == `AOC_STATUS_OFS >> 2) ?
          `AOC_RESP_OKAY : `AOC_RESP_SLVERR;
      end else if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end
  // control register with byte strobes
  always @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= `AOC_CTRL_RST;
    end else if (wr_do && awaddr_reg[3:2] == `AOC_CTRL_OFS >> 2) begin
      if (wstrb_reg[0]) begin
        ctrl_reg[7:0] <= wdata_reg[7:0];
      end
      if (wstrb_reg[1]) begin
        ctrl_reg[9:8] <= wdata_reg[9:8];
      end
    end
  end
  // conversion gap watch outside accurate mode, late flag cleared by writing one
  always @(posedge aclk) begin
    if (!aresetn) begin
      gap_reg <= 32'h00000000;
      late_reg <= 1'b0;
    end else begin
      if (conv_taken || mode_onehot[2]) begin
        gap_reg <= 32'h00000000;
      end else if (gap_reg < MAX_GAP_CYC) begin
        gap_reg <= gap_reg + 32'h00000001;
      end
      if (!mode_onehot[2] && gap_reg == MAX_GAP_CYC - 1) begin
        late_reg <= 1'b1;
      end else if (wr_do && awaddr_reg[3:2] == `AOC_STATUS_OFS >> 2 && wstrb_reg[0] && wdata_reg[`AOC_S_LATE]) begin
        late_reg <= 1'b0;
      end
    end
  end
  // status word
  assign status_word = {20'h00000, level, 3'h0, (state_reg == ST_SHIFT), late_reg, mode_onehot};
  // axi read
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  always @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= `AOC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_reg <= 1'b1;
      case (s_axi_araddr[3:2])
        `AOC_CTRL_OFS >> 2: begin
          rdata_reg <= {22'h000000, ctrl_reg};
          rresp_reg <= `AOC_RESP_OKAY;
        end
        `AOC_STATUS_OFS >> 2: begin
          rdata_reg <= status_word;
          rresp_reg <= `AOC_RESP_OKAY;
        end
        default: begin
          rdata_reg <= 32'h00000000;
          rresp_reg <= `AOC_RESP_SLVERR;
        end
      endcase
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end
  // parallel output word
  always @(posedge aclk) begin
    if (!aresetn) begin
      par_word_reg <= 16'h0000;
    end else if (!serial_mode && pop_next) begin
      par_word_reg <= fmt_word;
    end
  end

  // byte order on the bus halves
  assign d_out = ctrl_reg[`AOC_C_HALF] ? {par_word_reg[7:0], par_word_reg[15:8]} : par_word_reg;
  // pin enables: parallel drives all, serial only the two lowest
  assign d_oe = serial_mode ? 16'h0003 : 16'hFFFF;

  // serial engine
  always @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= ST_IDLE;
      shift_reg <= 16'h0000;
      bits_reg <= 5'h00;
      pcnt_reg <= 7'h00;
      sclk_reg <= 1'b0;
      sclk_in_prev_reg <= 1'b0;
      sdo_reg <= 1'b0;
    end else begin
      sclk_in_prev_reg <= sclk_in;
      case (state_reg)
        ST_IDLE: begin
          pcnt_reg <= 7'h00;
          sclk_reg <= 1'b0;
          if (serial_mode && pop_next) begin
            shift_reg <= {fmt_word[14:0], 1'b0};
            sdo_reg <= fmt_word[15];
            sclk_reg <= master_mode;
            bits_reg <= 5'h10;
            state_reg <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          if (cs_n) begin
            state_reg <= ST_IDLE;
          end else begin
            pcnt_reg <= shift_tick ? 7'h00 : pcnt_reg + 7'h01;
            sclk_reg <= master_mode && !(shift_tick && bits_reg == 5'h01) &&
              ((shift_tick ? 7'h00 : pcnt_reg + 7'h01) < (period_next >> 1));
            if (shift_tick) begin
              sdo_reg <= shift_reg[15];
              shift_reg <= {shift_reg[14:0], 1'b0};
              bits_reg <= bits_reg - 5'h01;
              if (bits_reg == 5'h01) begin
                state_reg <= ST_IDLE;
              end
            end
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  assign sclk_out = sclk_reg;
  assign sclk_oe = master_mode && !cs_n;
  assign serial_result_out = sdo_reg;
  assign serial_result_oe = serial_mode && !cs_n;
endmodule // aoc_top

// [sim/aoc_checker.sv]
`timescale 1ns/1ps
// port-level checks on pin enables and register bus handshakes
module aoc_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic cs_n,
  input wire logic [15:0] d_oe,
  input wire logic sclk_oe,
  input wire logic serial_result_oe
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // both write halves taken at one edge
  sequence wr_both_s;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  low_pins_on_a: assert property (d_oe[1:0] == 2'h3)
    else $error("low pins not driven");
  oe_shape_a: assert property (d_oe == 16'hFFFF || d_oe == 16'h0003)
    else $error("bad pin enable set");
  div_float_a: assert property (!d_oe[4] |-> d_oe[3:2] == 2'h0)
    else $error("divide pins driven");
  ser_oe_gate_a: assert property (serial_result_oe |-> !cs_n && d_oe == 16'h0003)
    else $error("serial out driven wrongly");
  master_clk_a: assert property (sclk_oe |-> serial_result_oe)
    else $error("clock driven outside frame");
  wr_resp_a: assert property (wr_both_s |=> ##1 s_axi_bvalid)
    else $error("write response late");
  wr_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during response");
  rd_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
endmodule // aoc_checker

bind aoc_top aoc_checker aoc_checker_inst (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .cs_n, .d_oe, .sclk_oe,
  .serial_result_oe);

// [sim/aoc_host.sv]
`timescale 1ns/1ps
// host side: pops parallel words and reads serial frames
module aoc_host (
  input wire logic aclk,
  input wire logic sclk_out,
  input wire logic serial_result_out,
  output logic par_read,
  output logic cs_n,
  output logic sclk_in
);
  // link clock stands low outside frames
  initial begin
    par_read = 1'h0;
    cs_n = 1'h1;
    sclk_in = 1'h0;
  end
  // one parallel pop pulse
  task automatic par_pop();
    @(posedge aclk) par_read <= 1'h1;
    @(posedge aclk) par_read <= 1'h0;
  endtask
  // one serial frame; per is the master clock period in cycles
  task automatic ser_get(input logic slave, output logic [15:0] w, output int per);
    int t = 0, t0 = 0, i = 0;
    logic last = 1'h0;
    per = 0;
    w = 16'h0;
    @(posedge aclk) cs_n <= 1'h0;
    if (slave) begin
      repeat (3) @(posedge aclk);
      for (i = 0; i < 16; i++) begin
        w = {w[14:0], serial_result_out};
        sclk_in <= 1'h1;
        repeat (3) @(posedge aclk);
        sclk_in <= 1'h0;
        repeat (3) @(posedge aclk);
      end
    end else begin
      while (i < 16 && t < 2000) begin
        @(negedge aclk); // sample the link mid-cycle, once it has settled
        t++;
        if (sclk_out && !last) begin
          w = {w[14:0], serial_result_out};
          if (i == 1) per = t - t0;
          t0 = t;
          i++;
        end
        last = sclk_out;
      end
    end
    @(posedge aclk) cs_n <= 1'h1;
  endtask
endmodule // aoc_host

// [sim/tb_top.sv]
`timescale 1ns/1ps
`define check_eq(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin num_errors++; \
  $display("wrong value %s exp %0h got %0h", nm, ex, got); end end
module tb_top;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
  logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, conv_valid;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, conv_ready;
  logic par_read, cs_n, sclk_in, sclk_out, sclk_oe, serial_result_out, serial_result_oe;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [15:0] conv_data = 16'h0, d_out, d_oe;
  logic [2:0] mexp [4] = '{3'h4, 3'h2, 3'h0, 3'h1};
  int num_errors = 0, tests_run = 0;

  // 200 MHz clock
  always #2.5 aclk = ~aclk;

  aoc_top #(.MAX_GAP_CYC(50)) aoc_top_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .conv_data(conv_data), .conv_valid(conv_valid), .conv_ready(conv_ready),
    .par_read(par_read), .d_out(d_out), .d_oe(d_oe), .cs_n(cs_n), .sclk_in(sclk_in), .sclk_out(sclk_out),
    .sclk_oe(sclk_oe), .serial_result_out(serial_result_out), .serial_result_oe(serial_result_oe));
  aoc_host aoc_host_inst (.aclk(aclk), .sclk_out(sclk_out), .serial_result_out(serial_result_out),
    .par_read(par_read), .cs_n(cs_n), .sclk_in(sclk_in));

  // verdict and end of run
  task automatic results();
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // one register write, response checked against the map
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid && ++n < 200);
    s_axi_bready <= 1'h0;
    `check_eq("bvalid", 1'h1, s_axi_bvalid)
    `check_eq("bresp", a[3] ? 2'h2 : 2'h0, s_axi_bresp)
  endtask

  // one register read
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    int n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid && ++n < 200);
    s_axi_rready <= 1'h0;
    d = s_axi_rdata;
    `check_eq("rvalid", 1'h1, s_axi_rvalid)
    `check_eq("rresp", a[3] ? 2'h2 : 2'h0, s_axi_rresp)
  endtask

  // one conversion result into the buffer
  task automatic push(input logic [15:0] v);
    int n = 0;
    @(posedge aclk);
    conv_data <= v;
    conv_valid <= 1'h1;
    do @(posedge aclk); while (!conv_ready && ++n < 200);
    conv_valid <= 1'h0;
    `check_eq("push_taken", 1'h1, conv_ready)
  endtask

  // main sequence
  initial begin
    logic [31:0] r;
    logic [15:0] w, v;
    int per, e;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, conv_valid} = 6'h0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'h1;
    rd(4'h0, r);
    `check_eq("ctrl", 32'h0, r)
    rd(4'h4, r);
    `check_eq("status", 32'h4, r)
    `check_eq("d_oe", 16'hFFFF, d_oe)
    for (int m = 0; m < 4; m++) begin
      wr(4'h0, m << 2);
      rd(4'h4, r);
      `check_eq("mode", mexp[m], r[2:0])
    end
    wr(4'h0, 32'h4);
    repeat (60) @(posedge aclk);
    rd(4'h4, r);
    `check_eq("late", 1'h1, r[3])
    wr(4'h0, 32'h0);
    wr(4'h4, 32'h8);
    repeat (60) @(posedge aclk);
    rd(4'h4, r);
    `check_eq("status", 32'h4, r)
    wr(4'h8, 32'h0);
    rd(4'h8, r);
    for (int k = 0; k < 4; k++) begin
      wr(4'h0, k);
      push(16'h8A35);
      aoc_host_inst.par_pop();
      @(posedge aclk);
      v = k[1] ? 16'h8A35 : 16'h0A35;
      `check_eq("d_out", k[0] ? {v[7:0], v[15:8]} : v, d_out)
    end
    wr(4'h0, 32'h2);
    for (int i = 0; i < 8; i++) push(16'h1000 + i);
    @(posedge aclk);
    `check_eq("conv_ready", 1'h0, conv_ready)
    rd(4'h4, r);
    `check_eq("status", 32'h804, r)
    for (int i = 0; i < 9; i++) begin
      aoc_host_inst.par_pop();
      @(posedge aclk);
      `check_eq("d_out", 16'h1000 + (i < 8 ? i : 7), d_out)
    end
    for (int i = 0; i < 5; i++) begin
      e = (i < 4) ? i : 3;
      wr(4'h0, 32'h12 | ((i == 4) << 6) | (e << 8));
      push(16'hC35A + i);
      aoc_host_inst.ser_get(1'h0, w, per);
      `check_eq("ser_word", 16'hC35A + i, w)
      `check_eq("period", (i < 4) ? ((8 << e) + 4) / 5 : 2, per)
      `check_eq("d_oe", 16'h0003, d_oe)
    end
    wr(4'h0, 32'h332);
    push(16'h5AC3);
    aoc_host_inst.ser_get(1'h1, w, per);
    `check_eq("ser_word", 16'h5AC3, w)
    results();
  end

  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge aclk);
    num_errors++;
    results();
  end
endmodule // tb_top
